// ==== hw/iop_pkg.sv ====
package iop_pkg;

  // bus and port geometry
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned OUT_BITS    = 8;
  localparam int unsigned IN_BITS     = 8;
  localparam int unsigned EXT_LINES   = 64;
  localparam int unsigned AN_CHANS    = 8;
  localparam int unsigned AN_MAX_W    = 16;
  localparam int unsigned PC_W        = 16;
  localparam int unsigned SEL_W       = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_OUT_WORD  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OUT_SET   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OUT_CLR   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OUT_COND  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IN_LEVEL  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IN_HOLD   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_RANGE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_HANDLER   = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SAVED_PC  = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_DIR_LO    = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_DIR_HI    = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_XOUT_LO   = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_XOUT_HI   = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_XIN_LO    = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_XIN_HI    = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_AN_SEL    = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_AN_DATA   = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT  = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 8'h4C;

  // field positions
  localparam int unsigned FLD_COND_VAL  = 8;   // value field of a conditional write
  localparam int unsigned FLD_HOLD_LOW  = 3;   // wait for low level instead of high
  localparam int unsigned FLD_HOLD_BUSY = 31;  // stall in progress (read)
  localparam int unsigned FLD_RANGE_END = 8;   // last input of a range
  localparam int unsigned FLD_RET       = 0;   // return from handler (write)
  localparam int unsigned FLD_STK_CLR   = 1;   // drop saved point, leave handler (write)
  localparam int unsigned FLD_AN_VALID  = 31;  // sample present (read)
  localparam int unsigned EVT_W         = 3;

  // reset values
  localparam logic [OUT_BITS-1:0]  RST_OUT  = 8'h00;
  localparam logic [IN_BITS-1:0]   RST_IEN  = 8'h00;
  localparam logic [EXT_LINES-1:0] RST_DIR  = 64'h0;
  localparam logic [DATA_W-1:0]    RD_ZERO  = 32'h0000_0000;

  // hardware events that set sticky status bits
  typedef struct packed {
    logic anDone;     // conversion stored
    logic irqTaken;   // input interrupt entered
    logic holdDone;   // input wait released
  } iop_evt_s;

  // resume request to the program engine
  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] pc;
  } iop_resume_s;

  // converter request
  typedef struct packed {
    logic             start;
    logic [SEL_W-1:0] chan;
  } iop_conv_s;

endpackage

// ==== hw/iop_pin_sync.sv ====
module iop_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pinRaw,
  output logic      [WIDTH-1:0] pinLevel
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // three-flop chain; only stage2 reads stage1
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinRaw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts once the two late stages agree, which rejects one-cycle glitches
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinLevel <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          pinLevel[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// ==== hw/iop_sample_mem.sv ====
module iop_sample_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 16,
  parameter int unsigned AW    = 3
) (
  // clock
  input  wire logic             core_clk,
  // write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // registered read port
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] store [DEPTH];

  // plain array with no reset so it maps onto distributed ram
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end
endmodule

// ==== hw/iop_port_top.sv ====
// Functional notes
// - An eight-bit general output port drives external events with no fixed function.
// - Sixty-four extra lines each act as input or output per a direction setting.
// - Any output bit can be set or cleared alone without touching the others.
// - A conditional bit write sets the bit for a nonzero value and clears it for zero.
// - A word write loads all eight outputs, bit 0 is output 1, and 255 turns all on.
// - Eight digital inputs return their present level when read.
// - An input wait stalls the program until the input is high, or low when negated.
// - Interrupt enables are given as a first and last input range or as an eight-bit mask.
// - A low level on an enabled input diverts execution to the input handler.
// - Returning from the handler resumes at the exact point where it was entered.
// - Eight analog channels can each be read on demand.
// - Conversions are twelve bits by default with a sixteen-bit option.
module iop_port_top
  import iop_pkg::*;
#(
  parameter int unsigned AN_BITS = 12
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [iop_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [iop_pkg::DATA_W-1:0]    pwdata,
  output logic      [iop_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  // general output port and digital inputs
  output logic      [iop_pkg::OUT_BITS-1:0]  outPort,
  input  wire logic [iop_pkg::IN_BITS-1:0]   inPin,
  // extra lines, split into input, output and enable
  input  wire logic [iop_pkg::EXT_LINES-1:0] extIn,
  output logic      [iop_pkg::EXT_LINES-1:0] extOut,
  output logic      [iop_pkg::EXT_LINES-1:0] extOe,
  // converter
  output iop_pkg::iop_conv_s                 convReq,
  input  wire logic [iop_pkg::AN_MAX_W-1:0]  convData,
  input  wire logic                          convDone,
  // program engine
  input  wire logic [iop_pkg::PC_W-1:0]      progPc,
  output logic                               progStall,
  output logic                               handlerReq,
  output logic                               handlerActive,
  output iop_pkg::iop_resume_s               resume,
  // interrupt
  output logic                               irq
);
  import iop_pkg::*;

  logic [IN_BITS-1:0]   inLevel;
  logic [EXT_LINES-1:0] extLevel;
  logic                 doneLevel;
  logic                 donePrev;
  logic [IN_BITS-1:0]   irqEnable;
  logic                 holdLow;
  logic [SEL_W-1:0]     holdSel;
  logic [PC_W-1:0]      savedPc;
  logic                 anValid [AN_CHANS];
  logic [AN_MAX_W-1:0]  anRdData;
  logic [SEL_W-1:0]     anSel;
  logic                 anBusy;
  iop_evt_s             evtStat;
  iop_evt_s             evtMask;
  iop_evt_s             evtNow;
  logic                 busAccess;
  logic                 busCommit;
  logic                 wrCommit;
  logic                 rdCommit;
  logic                 addrHit;
  logic [DATA_W-1:0]    next_prdata;
  logic [IN_BITS-1:0]   rangeMask;
  logic                 holdMet;
  logic                 irqFire;
  logic [AN_MAX_W-1:0]  convTrim;
  logic                 convEdge;

  // inputs, extra lines and convDone go through the filtered three-flop chain; convData does not
  iop_pin_sync #(.WIDTH(IN_BITS)) uSyncIn (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinRaw   (inPin),
    .pinLevel (inLevel)
  );

  iop_pin_sync #(.WIDTH(EXT_LINES)) uSyncExt (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinRaw   (extIn),
    .pinLevel (extLevel)
  );

  iop_pin_sync #(.WIDTH(1)) uSyncDone (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinRaw   (convDone),
    .pinLevel (doneLevel)
  );

  // apb handshake: one wait state, the transfer completes when pready is seen high
  assign busAccess = psel && penable && !pready;
  assign busCommit = psel && penable && pready;
  assign wrCommit  = busCommit && pwrite;
  assign rdCommit  = busCommit && !pwrite;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= busAccess;
    end
  end

  // address decode, unmapped offsets answer with an error
  always_comb begin
    unique case (paddr)
      OFF_OUT_WORD, OFF_OUT_SET, OFF_OUT_CLR, OFF_OUT_COND, OFF_IN_LEVEL, OFF_IN_HOLD,
      OFF_IRQ_RANGE, OFF_IRQ_EN, OFF_HANDLER, OFF_SAVED_PC, OFF_DIR_LO, OFF_DIR_HI,
      OFF_XOUT_LO, OFF_XOUT_HI, OFF_XIN_LO, OFF_XIN_HI, OFF_AN_SEL, OFF_AN_DATA,
      OFF_EVT_STAT, OFF_EVT_MASK: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= busAccess && !addrHit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      outPort <= RST_OUT;
    end else if (wrCommit) begin
      unique case (paddr)
        OFF_OUT_WORD: outPort <= pwdata[OUT_BITS-1:0];
        OFF_OUT_SET:  outPort[pwdata[SEL_W-1:0]] <= 1'b1;
        OFF_OUT_CLR:  outPort[pwdata[SEL_W-1:0]] <= 1'b0;
        OFF_OUT_COND: outPort[pwdata[SEL_W-1:0]] <= |pwdata[DATA_W-1:FLD_COND_VAL];
        default:      outPort <= outPort;
      endcase
    end
  end

  // extra lines: direction doubles as output enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      extOe  <= RST_DIR;
      extOut <= RST_DIR;
    end else if (wrCommit) begin
      unique case (paddr)
        OFF_DIR_LO:  extOe[DATA_W-1:0]          <= pwdata;
        OFF_DIR_HI:  extOe[EXT_LINES-1:DATA_W]  <= pwdata;
        OFF_XOUT_LO: extOut[DATA_W-1:0]         <= pwdata;
        OFF_XOUT_HI: extOut[EXT_LINES-1:DATA_W] <= pwdata;
        default:     extOut <= extOut;
      endcase
    end
  end

  // range form of the enable: inputs first..last inclusive, empty when reversed
  always_comb begin
    rangeMask = '0;
    for (int i = 0; i < IN_BITS; i++) begin
      if ((SEL_W'(i) >= pwdata[SEL_W-1:0]) && (SEL_W'(i) <= pwdata[FLD_RANGE_END +: SEL_W])) begin
        rangeMask[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEnable <= RST_IEN;
    end else if (wrCommit && paddr == OFF_IRQ_RANGE) begin
      irqEnable <= rangeMask;
    end else if (wrCommit && paddr == OFF_IRQ_EN) begin
      irqEnable <= pwdata[IN_BITS-1:0];
    end
  end

  // input wait: stall holds until the chosen input reaches the wanted level
  assign holdMet = holdLow ? !inLevel[holdSel] : inLevel[holdSel];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      progStall <= 1'b0;
      holdLow   <= 1'b0;
      holdSel   <= '0;
    end else if (wrCommit && paddr == OFF_IN_HOLD) begin
      progStall <= 1'b1;
      holdLow   <= pwdata[FLD_HOLD_LOW];
      holdSel   <= pwdata[SEL_W-1:0];
    end else if (progStall && holdMet) begin
      progStall <= 1'b0;
    end
  end

  // input interrupt; the handler blocks re-entry so a held-low input cannot recurse
  // held off in handler
  assign irqFire = |(irqEnable & ~inLevel) && !handlerActive;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      handlerActive <= 1'b0;
      handlerReq    <= 1'b0;
      savedPc       <= '0;
      resume        <= '0;
    end else begin
      handlerReq  <= 1'b0;
      resume.load <= 1'b0;
      if (irqFire) begin
        handlerReq    <= 1'b1;
        handlerActive <= 1'b1;
        savedPc       <= progPc;
      end else if (wrCommit && paddr == OFF_HANDLER && handlerActive) begin
        if (pwdata[FLD_STK_CLR]) begin
          handlerActive <= 1'b0;
        end else if (pwdata[FLD_RET]) begin
          handlerActive <= 1'b0;
          resume.load   <= 1'b1;
          resume.pc     <= savedPc;
        end
      end
    end
  end

  // converter: one request at a time, result kept per channel
  assign convTrim = (AN_BITS < AN_MAX_W) ? (convData & AN_MAX_W'((1 << AN_BITS) - 1)) : convData;
  assign convEdge = doneLevel && !donePrev && anBusy;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      convReq  <= '0;
      anSel    <= '0;
      anBusy   <= 1'b0;
      donePrev <= 1'b0;
    end else begin
      donePrev      <= doneLevel;
      convReq.start <= 1'b0;
      if (wrCommit && paddr == OFF_AN_SEL && !anBusy) begin
        convReq.start <= 1'b1;
        convReq.chan  <= pwdata[SEL_W-1:0];
        anSel         <= pwdata[SEL_W-1:0];
        anBusy        <= 1'b1;
      end else if (convEdge) begin
        anBusy <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < AN_CHANS; i++) begin
        anValid[i] <= 1'b0;
      end
    end else if (convEdge) begin
      anValid[anSel] <= 1'b1;
    end
  end

  iop_sample_mem #(.DEPTH(AN_CHANS), .WIDTH(AN_MAX_W), .AW(SEL_W)) uSamples (
    .core_clk (core_clk),
    .wrEn     (convEdge),
    .wrAddr   (anSel),
    .wrData   (convTrim),
    .rdAddr   (anSel),
    .rdData   (anRdData)
  );

  // sticky events: a set in the same cycle as the clearing read wins
  assign evtNow.anDone   = convEdge;
  assign evtNow.irqTaken = irqFire;
  assign evtNow.holdDone = progStall && holdMet && !(wrCommit && paddr == OFF_IN_HOLD);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      evtStat <= '0;
      evtMask <= '0;
    end else begin
      if (rdCommit && paddr == OFF_EVT_STAT) begin
        evtStat <= evtNow;
      end else begin
        evtStat <= evtStat | evtNow;
      end
      if (wrCommit && paddr == OFF_EVT_MASK) begin
        evtMask <= pwdata[EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evtStat & evtMask);
    end
  end

  // read mux, captured in the wait cycle so data stands while pready is high
  always_comb begin
    next_prdata = RD_ZERO;
    unique case (paddr)
      OFF_OUT_WORD:  next_prdata[OUT_BITS-1:0] = outPort;
      OFF_IN_LEVEL:  next_prdata[IN_BITS-1:0]  = inLevel;
      OFF_IN_HOLD: begin
        next_prdata[SEL_W-1:0]     = holdSel;
        next_prdata[FLD_HOLD_LOW]  = holdLow;
        next_prdata[FLD_HOLD_BUSY] = progStall;
      end
      OFF_IRQ_EN:    next_prdata[IN_BITS-1:0]  = irqEnable;
      OFF_HANDLER:   next_prdata[FLD_RET]      = handlerActive;
      OFF_SAVED_PC:  next_prdata[PC_W-1:0]     = savedPc;
      OFF_DIR_LO:    next_prdata = extOe[DATA_W-1:0];
      OFF_DIR_HI:    next_prdata = extOe[EXT_LINES-1:DATA_W];
      OFF_XOUT_LO:   next_prdata = extOut[DATA_W-1:0];
      OFF_XOUT_HI:   next_prdata = extOut[EXT_LINES-1:DATA_W];
      OFF_XIN_LO:    next_prdata = extLevel[DATA_W-1:0];
      OFF_XIN_HI:    next_prdata = extLevel[EXT_LINES-1:DATA_W];
      OFF_AN_SEL: begin
        next_prdata[SEL_W-1:0]     = anSel;
        next_prdata[FLD_HOLD_BUSY] = anBusy;
      end
      OFF_AN_DATA: begin
        next_prdata[AN_MAX_W-1:0] = anRdData;
        next_prdata[FLD_AN_VALID] = anValid[anSel];
      end
      OFF_EVT_STAT:  next_prdata[EVT_W-1:0]    = evtStat;
      OFF_EVT_MASK:  next_prdata[EVT_W-1:0]    = evtMask;
      default:       next_prdata = RD_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= RD_ZERO;
    end else if (busAccess && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule

// ==== tb/iop_far_side.sv ====
module iop_far_side
  import iop_pkg::*;
(
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  // switch levels chosen by the bench
  input  wire logic [iop_pkg::IN_BITS-1:0]   swLevel,
  // pins toward the block
  output logic      [iop_pkg::IN_BITS-1:0]   inPin,
  input  wire logic [iop_pkg::EXT_LINES-1:0] extOut,
  input  wire logic [iop_pkg::EXT_LINES-1:0] extOe,
  output logic      [iop_pkg::EXT_LINES-1:0] extIn,
  // converter
  input  wire iop_pkg::iop_conv_s            convReq,
  output logic      [iop_pkg::AN_MAX_W-1:0]  convData,
  output logic                               convDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [2:0] chan;
  // switches follow the bench directly
  assign inPin = swLevel;
  // released lines float to their pull-up level
  assign extIn = (extOut & extOe) | ~extOe;
  // sensor sample: data settles a cycle before done, is scrambled once done drops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= 4'h0;
      chan     <= 3'h0;
      convDone <= 1'b0;
      convData <= 16'hFFFF;
    end else if (convReq.start) begin
      cnt      <= 4'hB;
      chan     <= convReq.chan;
      convDone <= 1'b0;
    end else if (cnt != 4'h0) begin
      cnt      <= cnt - 4'h1;
      convDone <= (cnt <= 4'h8) && (cnt > 4'h2);
      if (cnt == 4'h9) convData <= 16'hF5A0 + {13'h0, chan};
      if (cnt == 4'h2) convData <= ~convData;
    end
  end
endmodule

// ==== tb/iop_port_sva.sv ====
module iop_port_sva
  import iop_pkg::*;
#(
  parameter int unsigned AN_BITS = 12
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  // apb
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [iop_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [iop_pkg::DATA_W-1:0]   pwdata,
  input  wire logic                         pready,
  input  wire logic                         pslverr,
  // port, converter and engine
  input  wire logic [iop_pkg::OUT_BITS-1:0] outPort,
  input  wire iop_pkg::iop_conv_s           convReq,
  input  wire logic [iop_pkg::PC_W-1:0]     progPc,
  input  wire logic                         handlerReq,
  input  wire logic                         handlerActive,
  input  wire iop_pkg::iop_resume_s         resume
);
  import iop_pkg::*;
  logic [PC_W-1:0]     pcPrev;
  logic [PC_W-1:0]     savedPc;
  logic [OUT_BITS-1:0] bitSel;
  logic [OUT_BITS-1:0] setExp;
  logic [OUT_BITS-1:0] clrExp;
  logic [OUT_BITS-1:0] condExp;
  logic                selDone;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // expected port after a single-bit access, sampled at the commit edge
  assign bitSel  = 8'h01 << pwdata[2:0];
  assign setExp  = outPort | bitSel;
  assign clrExp  = outPort & ~bitSel;
  assign condExp = (|pwdata[31:8]) ? setExp : clrExp;
  assign selDone = psel && penable && pready && pwrite && (paddr == OFF_AN_SEL);
  // program point of the cycle the handler was entered from
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcPrev  <= 16'h0000;
      savedPc <= 16'h0000;
    end else begin
      pcPrev <= progPc;
      if (handlerReq) savedPc <= pcPrev;
    end
  end
  sequence s_wr(logic [ADDR_W-1:0] off);
    psel && penable && pready && pwrite && (paddr == off);
  endsequence
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 (pready || !psel);
  endsequence
  a_reset_out_clear: assert property ($rose(rst_b) |-> outPort == RST_OUT)
    else $error("output port not clear after reset");
  a_word_load: assert property (s_wr(OFF_OUT_WORD) |=> outPort == $past(pwdata[7:0]))
    else $error("word write did not load the port");
  a_set_one_bit: assert property (s_wr(OFF_OUT_SET) |=> outPort == $past(setExp))
    else $error("single-bit set touched the wrong bits");
  a_clear_one_bit: assert property (s_wr(OFF_OUT_CLR) |=> outPort == $past(clrExp))
    else $error("single-bit clear touched the wrong bits");
  a_cond_bit: assert property (s_wr(OFF_OUT_COND) |=> outPort == $past(condExp))
    else $error("conditional write gave the wrong port");
  a_entry_not_nested: assert property (handlerReq |-> handlerActive && !$past(handlerActive))
    else $error("handler entered while already active");
  a_entry_pulse: assert property (handlerReq |=> !handlerReq)
    else $error("handler request longer than one cycle");
  a_resume_point: assert property (resume.load |-> resume.pc == savedPc && !handlerActive && $past(handlerActive))
    else $error("resume point differs from entry point");
  a_one_wait_state: assert property (s_setup |=> s_one_wait)
    else $error("bus answer not in second access cycle");
  a_unmapped_err: assert property (pready && psel && paddr > OFF_EVT_MASK |-> pslverr)
    else $error("unmapped access without error");
  a_conv_from_sel: assert property ($rose(convReq.start) |-> $past(selDone) || $past(selDone, 2))
    else $error("conversion started without a select");
endmodule

bind iop_port_top iop_port_sva #(.AN_BITS(AN_BITS)) u_iop_port_sva (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .outPort(outPort),
  .convReq(convReq), .progPc(progPc), .handlerReq(handlerReq), .handlerActive(handlerActive),
  .resume(resume)
);

// ==== tb/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iop_pkg::*;
  logic                 core_clk, rst_b, psel, penable, pwrite, pready, pslverr, lastErr;
  logic                 progStall, handlerReq, handlerActive, irq, convDone;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata, prdata, rdVal;
  logic [OUT_BITS-1:0]  outPort;
  logic [IN_BITS-1:0]   inPin, swLevel;
  logic [EXT_LINES-1:0] extIn, extOut, extOe;
  logic [AN_MAX_W-1:0]  convData;
  logic [PC_W-1:0]      progPc, lastResume;
  iop_conv_s            convReq;
  iop_resume_s          resume;
  int                   errors, nCompared, nEntries, nResumes, n;

  iop_port_top #(.AN_BITS(12)) u_iop_port_top (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .outPort(outPort), .inPin(inPin), .extIn(extIn), .extOut(extOut), .extOe(extOe),
    .convReq(convReq), .convData(convData), .convDone(convDone), .progPc(progPc), .progStall(progStall),
    .handlerReq(handlerReq), .handlerActive(handlerActive), .resume(resume), .irq(irq));
  iop_far_side u_iop_far_side (.core_clk(core_clk), .rst_b(rst_b), .swLevel(swLevel), .inPin(inPin),
    .extOut(extOut), .extOe(extOe), .extIn(extIn), .convReq(convReq), .convData(convData), .convDone(convDone));

  always #25 core_clk = ~core_clk;
  // count pulses away from the launching edge
  always @(negedge core_clk) begin
    if (handlerReq === 1'b1) nEntries++;
    if (resume.load === 1'b1) begin
      nResumes++;
      lastResume = resume.pc;
    end
  end

  task automatic giveVerdict();
    if (errors == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; returns at the falling edge after release so outputs have settled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) begin errors++; giveVerdict(); end
      @(posedge core_clk);
    end
    rdVal = prdata;
    lastErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdVal, exp);
  endtask

  task automatic pins(input logic [7:0] lvl);
    @(posedge core_clk);
    swLevel <= lvl;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return progStall;
      1: return handlerActive;
      default: return irq;
    endcase
  endfunction

  task automatic waitOut(input int w, input logic lvl);
    int k;
    k = 0;
    @(negedge core_clk);
    while (pick(w) !== lvl) begin
      k++;
      if (k > 50) begin errors++; giveVerdict(); end
      @(negedge core_clk);
    end
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    giveVerdict();
  end

  initial begin
    core_clk = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; swLevel = 8'hFF; progPc = 16'h1234;
    errors = 0; nCompared = 0; nEntries = 0; nResumes = 0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    chk(32'(outPort), 32'h0000_0000);
    rdc(OFF_IRQ_EN, 32'h0000_0000);
    wr(OFF_OUT_WORD, 32'h0000_0006); chk(32'(outPort), 32'h0000_0006);
    wr(OFF_OUT_WORD, 32'h0000_00FF); rdc(OFF_OUT_WORD, 32'h0000_00FF);
    wr(OFF_OUT_WORD, 32'h0000_0000);
    wr(OFF_OUT_SET, 32'h0000_0005); chk(32'(outPort), 32'h0000_0020);
    wr(OFF_OUT_SET, 32'h0000_0000); chk(32'(outPort), 32'h0000_0021);
    wr(OFF_OUT_CLR, 32'h0000_0005); chk(32'(outPort), 32'h0000_0001);
    wr(OFF_OUT_COND, 32'h0000_0101); chk(32'(outPort), 32'h0000_0003);
    wr(OFF_OUT_COND, 32'h0000_0000); chk(32'(outPort), 32'h0000_0002);
    wr(OFF_OUT_COND, 32'h8000_0002); chk(32'(outPort), 32'h0000_0006);
    pins(8'hA5); repeat (8) @(posedge core_clk);
    rdc(OFF_IN_LEVEL, 32'h0000_00A5);
    wr(OFF_IN_HOLD, 32'h0000_0001); waitOut(0, 1'b1); chk(32'(progStall), 32'h1);
    pins(8'hA7); waitOut(0, 1'b0); chk(32'(progStall), 32'h0);
    wr(OFF_IN_HOLD, 32'h0000_000F); waitOut(0, 1'b1); chk(32'(progStall), 32'h1);
    pins(8'h27); waitOut(0, 1'b0); chk(32'(progStall), 32'h0);
    rdc(OFF_EVT_STAT, 32'h0000_0001);
    pins(8'hFF);
    wr(OFF_IRQ_RANGE, 32'h0000_0502); rdc(OFF_IRQ_EN, 32'h0000_003C);
    wr(OFF_IRQ_RANGE, 32'h0000_0205); rdc(OFF_IRQ_EN, 32'h0000_0000);
    wr(OFF_IRQ_EN, 32'h0000_0005); rdc(OFF_IRQ_EN, 32'h0000_0005);
    pins(8'hFB); waitOut(1, 1'b1);
    rdc(OFF_SAVED_PC, 32'h0000_1234);
    chk(32'(irq), 32'h0);
    @(posedge core_clk); progPc <= 16'h5555;
    pins(8'hFA); repeat (10) @(posedge core_clk);
    chk(32'(nEntries), 32'h1);
    pins(8'hFF); repeat (6) @(posedge core_clk);
    wr(OFF_HANDLER, 32'h0000_0001); waitOut(1, 1'b0); repeat (2) @(negedge core_clk);
    chk(32'(lastResume), 32'h0000_1234);
    chk(32'(nResumes), 32'h1);
    rdc(OFF_EVT_STAT, 32'h0000_0002);
    rdc(OFF_EVT_STAT, 32'h0000_0000);
    wr(OFF_EVT_MASK, 32'h0000_0002);
    pins(8'hFE); waitOut(1, 1'b1); waitOut(2, 1'b1); chk(32'(irq), 32'h1);
    pins(8'hFF); repeat (6) @(posedge core_clk);
    wr(OFF_HANDLER, 32'h0000_0002); waitOut(1, 1'b0); repeat (2) @(negedge core_clk);
    chk(32'(nResumes), 32'h1);
    rdc(OFF_EVT_STAT, 32'h0000_0002); waitOut(2, 1'b0); chk(32'(irq), 32'h0);
    for (int ch = 0; ch < 8; ch++) begin
      wr(OFF_AN_SEL, 32'(ch)); repeat (2) @(posedge core_clk);
      rdVal = 32'h8000_0000; n = 0;
      while (rdVal[31] !== 1'b0) begin
        apb(1'b0, OFF_AN_SEL, 32'h0000_0000);
        n++;
        if (n > 30) begin errors++; giveVerdict(); end
      end
      rdc(OFF_AN_DATA, 32'h8000_0000 | 32'((16'hF5A0 + 16'(ch)) & 16'h0FFF));
    end
    wr(OFF_DIR_LO, 32'h0000_00FF); wr(OFF_XOUT_LO, 32'h0000_00A5);
    chk(extOe[31:0], 32'h0000_00FF);
    chk(32'(extOut[7:0]), 32'h0000_00A5);
    repeat (6) @(posedge core_clk);
    rdc(OFF_XIN_LO, 32'hFFFF_FFA5);
    apb(1'b0, 8'h80, 32'h0000_0000); chk(32'(lastErr), 32'h1); chk(rdVal, 32'h0000_0000);
    giveVerdict();
  end
endmodule
